// [core/opa_align_top.sv]
// Output phase alignment sequencer, feedback selector and register file.
// Assumes an AXI4-Lite master on sys_clk and asynchronous pins.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "opa_params.svh"
module opa_align_top
   import opa_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins
   input wire logic alignPin,
   input wire logic external_feedback_input,
   input wire logic digital_lock_detect,
   // Clock outputs and loop
   output logic [`OPA_NUM_GRP-1:0] groupClk,
   output logic fbClk,
   output logic zeroDelayMode,
   output logic [24:0] loopDivide,
   output logic holdEnter
);
   // ----------------------------------------
   // Decoding helpers
   // ----------------------------------------
   // 0 ctrl, 1 status, 2 refdiv, 8+g group, 15 unmapped
   function automatic logic [3:0] decodeAddr(input logic [7:0] a);
      logic [3:0] r;
      r = 4'hF;
      if (a == `OPA_ADDR_CTRL) r = 4'h0;
      else if (a == `OPA_ADDR_STAT) r = 4'h1;
      else if (a == `OPA_ADDR_REFDIV) r = 4'h2;
      else if (a >= `OPA_ADDR_GRP0 && a < `OPA_ADDR_GRP0 + 8'(4 * `OPA_NUM_GRP) && a[1:0] == 2'h0)
         r = 4'h8 + 4'((a - `OPA_ADDR_GRP0) >> 2);
      return r;
   endfunction

   function automatic logic [31:0] mergeStrb(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[8*i +: 8] = n[8*i +: 8];
      end
      return r;
   endfunction

   // Selector shared by the qualifier and the feedback path
   function automatic logic pickSrc(input logic [2:0] sel, input logic [`OPA_NUM_GRP-1:0] g,
                                    input logic ext);
      logic r;
      r = 1'b0;
      if (sel == `OPA_SEL_EXT) r = ext;
      else if (sel < 3'(`OPA_NUM_GRP)) r = g[sel];
      return r;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic pinSync, extSync, lockSync;
   opa_sync3 uPin (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .din(alignPin), .dout(pinSync));
   opa_sync3 uExt (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .din(external_feedback_input),
                   .dout(extSync));
   opa_sync3 uLock (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .din(digital_lock_detect),
                    .dout(lockSync));

   // ----------------------------------------
   // Register file and bus slave
   // ----------------------------------------
   logic [31:0] ctrl_q, ctrl_d, refDiv_q, refDiv_d, rData_q, rData_d, rdMux;
   logic [31:0] grp_q [`OPA_NUM_GRP];
   logic [31:0] grp_d [`OPA_NUM_GRP];
   logic awReady_q, awReady_d, bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
   logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
   logic wrDone, rdDone, busy;
   logic [3:0] wIdx, rIdx;
   logic [`OPA_NUM_GRP-1:0] grpOut;
   logic oneShot_q;

   always_comb begin
      wrDone = s_axi_awvalid && s_axi_wvalid && awReady_q;
      rdDone = s_axi_arvalid && arReady_q;
      wIdx = decodeAddr(s_axi_awaddr);
      rIdx = decodeAddr(s_axi_araddr);
      // Address and data are taken together, so neither can run ahead
      awReady_d = !awReady_q && !bValid_q && s_axi_awvalid && s_axi_wvalid;
      arReady_d = !arReady_q && !rValid_q && s_axi_arvalid;
      bValid_d = bValid_q ? !s_axi_bready : wrDone;
      bResp_d = wrDone ? ((wIdx == 4'hF) ? `OPA_RESP_ERR : `OPA_RESP_OK) : bResp_q;
      rValid_d = rValid_q ? !s_axi_rready : rdDone;
      ctrl_d = ctrl_q;
      refDiv_d = refDiv_q;
      for (int g = 0; g < `OPA_NUM_GRP; g++) begin
         grp_d[g] = grp_q[g];
         if (wrDone && wIdx == 4'h8 + 4'(g)) grp_d[g] = mergeStrb(grp_q[g], s_axi_wdata, s_axi_wstrb);
      end
      if (wrDone && wIdx == 4'h0) ctrl_d = mergeStrb(ctrl_q, s_axi_wdata, s_axi_wstrb);
      if (wrDone && wIdx == 4'h2) refDiv_d = mergeStrb(refDiv_q, s_axi_wdata, s_axi_wstrb);
      rdMux = 32'h00000000;
      case (rIdx)
         4'h0: rdMux = ctrl_q;
         4'h1: rdMux = {16'h0000, 2'h0, grpOut, 2'h0, pinSync ^ ctrl_q[`OPA_CTRL_POLINV], lockSync,
                        holdEnter, zeroDelayMode, oneShot_q, busy};
         4'h2: rdMux = refDiv_q;
         default: begin
            if (rIdx >= 4'h8 && rIdx < 4'h8 + 4'(`OPA_NUM_GRP)) rdMux = grp_q[3'(rIdx - 4'h8)];
         end
      endcase
      rData_d = rdDone ? rdMux : rData_q;
      rResp_d = rdDone ? ((rIdx == 4'hF) ? `OPA_RESP_ERR : `OPA_RESP_OK) : rResp_q;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `OPA_CTRL_RST;
         refDiv_q <= `OPA_REFDIV_RST;
         for (int g = 0; g < `OPA_NUM_GRP; g++) grp_q[g] <= `OPA_GRP_RST;
         awReady_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= `OPA_RESP_OK;
         arReady_q <= 1'b0;
         rValid_q <= 1'b0;
         rResp_q <= `OPA_RESP_OK;
         rData_q <= 32'h00000000;
      end else if (ce) begin
         ctrl_q <= ctrl_d;
         refDiv_q <= refDiv_d;
         for (int g = 0; g < `OPA_NUM_GRP; g++) grp_q[g] <= grp_d[g];
         awReady_q <= awReady_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
         arReady_q <= arReady_d;
         rValid_q <= rValid_d;
         rResp_q <= rResp_d;
         rData_q <= rData_d;
      end
   end
   assign s_axi_awready = awReady_q;
   assign s_axi_wready = awReady_q;
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;
   assign s_axi_arready = arReady_q;
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rresp = rResp_q;
   assign s_axi_rdata = rData_q;

   // ----------------------------------------
   // Alignment sequencer
   // ----------------------------------------
   opa_state_t st_q, st_d;
   logic reqPrev_q, reqPrev_d, pend_q, pend_d, qualPrev_q, qualPrev_d, oneShot_d;
   logic forceLow_q, forceLow_d, release_q, release_d;
   logic [3:0] shotCnt_q, shotCnt_d;
   logic reqLevel, reqEdge, qualFall, alignEn;

   always_comb begin
      reqLevel = pinSync ^ ctrl_q[`OPA_CTRL_POLINV];
      reqEdge = reqLevel && !reqPrev_q;
      alignEn = ctrl_q[`OPA_CTRL_EN];
      qualPrev_d = pickSrc(ctrl_q[`OPA_CTRL_FBSEL], grpOut, extSync);
      // Without output qualification each stage advances at once
      qualFall = !ctrl_q[`OPA_CTRL_QUAL] || (qualPrev_q && !qualPrev_d);
      reqPrev_d = reqLevel;
      // A request edge arriving as the latch is consumed still wins
      pend_d = (pend_q && st_q == ST_IDLE) ? 1'b0 : pend_q;
      if (reqEdge && alignEn) pend_d = 1'b1;
      st_d = st_q;
      shotCnt_d = shotCnt_q;
      forceLow_d = 1'b0;
      release_d = 1'b0;
      oneShot_d = oneShot_q;
      case (st_q)
         ST_IDLE: begin
            if (pend_q) st_d = ST_QUAL1;
         end
         ST_QUAL1: begin
            if (qualFall) st_d = ST_QUAL2;
         end
         ST_QUAL2: begin
            if (qualFall) begin
               st_d = ST_SHOT;
               oneShot_d = 1'b1;
               shotCnt_d = 4'h1;
            end
         end
         ST_SHOT: begin
            shotCnt_d = shotCnt_q + 4'h1;
            if (shotCnt_q == `OPA_SHOT_LEN) begin
               oneShot_d = 1'b0;
               release_d = 1'b1;
            end
            if (shotCnt_q == `OPA_FORCE_LAG - 4'h1) begin // Pulse register and output flop add an edge
               forceLow_d = 1'b1;
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= ST_IDLE;
         reqPrev_q <= 1'b0;
         pend_q <= 1'b0;
         qualPrev_q <= 1'b0;
         oneShot_q <= 1'b0;
         forceLow_q <= 1'b0;
         release_q <= 1'b0;
         shotCnt_q <= 4'h0;
      end else if (ce) begin
         st_q <= st_d;
         reqPrev_q <= reqPrev_d;
         pend_q <= pend_d;
         qualPrev_q <= qualPrev_d;
         oneShot_q <= oneShot_d;
         forceLow_q <= forceLow_d;
         release_q <= release_d;
         shotCnt_q <= shotCnt_d;
      end
   end
   assign busy = (st_q != ST_IDLE) || pend_q;

   // ----------------------------------------
   // Output groups
   // ----------------------------------------
   generate
      for (genvar g = 0; g < `OPA_NUM_GRP; g++) begin : gGrp
         opa_grp_cfg_t cfg;
         assign cfg.div = grp_q[g][`OPA_GRP_DIV];
         assign cfg.ddly = grp_q[g][`OPA_GRP_DDLY];
         assign cfg.hs = grp_q[g][`OPA_GRP_HS];
         assign cfg.pd = grp_q[g][`OPA_GRP_PD];
         assign cfg.exempt = grp_q[g][`OPA_GRP_EXEMPT];
         opa_out_div uDiv (
            .sys_clk(sys_clk),
            .rst_b(rst_b),
            .ce(ce),
            .cfg(cfg),
            .forceLow(forceLow_q),
            .releaseGo(release_q),
            .clkOut(grpOut[g])
         );
      end
   endgenerate
   assign groupClk = grpOut;

   // ----------------------------------------
   // Feedback path and hold
   // ----------------------------------------
   logic fb_q, fb_d, zd_q, zd_d, hold_q, hold_d;
   logic [24:0] loop_q, loop_d;
   logic [10:0] fbDiv;

   always_comb begin
      zd_d = ctrl_q[`OPA_CTRL_MODE] == `OPA_MODE_ZD_A || ctrl_q[`OPA_CTRL_MODE] == `OPA_MODE_ZD_B;
      fb_d = ctrl_q[`OPA_CTRL_FBEN] && zd_d && pickSrc(ctrl_q[`OPA_CTRL_FBSEL], grpOut, extSync);
      fbDiv = 11'h001;
      if (ctrl_q[`OPA_CTRL_FBSEL] < 3'(`OPA_NUM_GRP)) fbDiv = grp_q[ctrl_q[`OPA_CTRL_FBSEL]][`OPA_GRP_DIV];
      loop_d = 25'(refDiv_q[13:0] * fbDiv);
      // Lock loss only matters for the zero-delay loop
      hold_d = zd_d && !lockSync && !ctrl_q[`OPA_CTRL_MASK];
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         fb_q <= 1'b0;
         zd_q <= 1'b0;
         hold_q <= 1'b0;
         loop_q <= 25'h0000000;
      end else if (ce) begin
         fb_q <= fb_d;
         zd_q <= zd_d;
         hold_q <= hold_d;
         loop_q <= loop_d;
      end
   end
   assign fbClk = fb_q;
   assign zeroDelayMode = zd_q;
   assign loopDivide = loop_q;
   assign holdEnter = hold_q;
endmodule

// [core/opa_out_div.sv]
// One clock output group: divider, forced low and delayed restart.
// Assumes force and release pulses from the alignment sequencer.
`timescale 1ns/1ps
module opa_out_div
   import opa_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Control
   input opa_grp_cfg_t cfg,
   input wire logic forceLow,
   input wire logic releaseGo,
   // Output
   output logic clkOut
);
   logic [10:0] cnt_q, cnt_d, divEff;
   logic [8:0] wait_q, wait_d;
   logic held_q, held_d, armed_q, armed_d, out_q, out_d;

   always_comb begin
      divEff = (cfg.div == 11'h000) ? 11'h001 : cfg.div;
      cnt_d = cnt_q;
      wait_d = wait_q;
      held_d = held_q;
      armed_d = armed_q;
      out_d = out_q;
      if (cfg.pd) begin
         cnt_d = 11'h000;
         out_d = 1'b0;
      end else begin
         if (!held_q) begin
            cnt_d = (cnt_q >= divEff - 11'h001) ? 11'h000 : cnt_q + 11'h001;
            // Half step swaps the halves, shifting phase by half a period
            out_d = (cnt_d < 11'(({1'b0, divEff} + 12'h001) >> 1)) ^ cfg.hs;
         end
         if (forceLow && !cfg.exempt) begin
            held_d = 1'b1;
            out_d = 1'b0;
         end
         if (releaseGo && !cfg.exempt) begin
            armed_d = 1'b1;
            // Arming edge and output flop already count toward the rise
            wait_d = `OPA_RISE_LAG + {1'b0, cfg.ddly} - 9'h002;
         end else if (armed_q) begin
            if (wait_q != 9'h000) begin
               wait_d = wait_q - 9'h001;
            end else begin
               armed_d = 1'b0;
               held_d = 1'b0;
               cnt_d = 11'h000;
               out_d = ~cfg.hs;
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_q <= 11'h000;
         wait_q <= 9'h000;
         held_q <= 1'b0;
         armed_q <= 1'b0;
         out_q <= 1'b0;
      end else if (ce) begin
         cnt_q <= cnt_d;
         wait_q <= wait_d;
         held_q <= held_d;
         armed_q <= armed_d;
         out_q <= out_d;
      end
   end
   assign clkOut = out_q;
endmodule

// [core/opa_params.svh]
// Constants for the output phase alignment and feedback block.
// Assumes inclusion by opa_pkg, by opa_align_top, by the checker and by the bench.
`ifndef OPA_PARAMS_SVH
`define OPA_PARAMS_SVH
// ----------------------------------------
// Sizes
// ----------------------------------------
`define OPA_NUM_GRP 6
`define OPA_SEL_EXT 3'h6
// ----------------------------------------
// Alignment timing, distribution cycles
// ----------------------------------------
`define OPA_SHOT_LEN 4'h3
`define OPA_FORCE_LAG 4'h5
`define OPA_RISE_LAG 9'h005
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define OPA_ADDR_CTRL 8'h00
`define OPA_ADDR_STAT 8'h04
`define OPA_ADDR_REFDIV 8'h08
`define OPA_ADDR_GRP0 8'h10
// ----------------------------------------
// Control fields
// ----------------------------------------
`define OPA_CTRL_RST 32'h00000001
`define OPA_CTRL_EN 0
`define OPA_CTRL_QUAL 1
`define OPA_CTRL_POLINV 2
`define OPA_CTRL_FBEN 3
`define OPA_CTRL_FBSEL 6:4
`define OPA_CTRL_MODE 11:8
`define OPA_CTRL_MASK 12
`define OPA_MODE_ZD_A 4'h2
`define OPA_MODE_ZD_B 4'h5
// ----------------------------------------
// Group fields, refdiv reset and bus response codes
// ----------------------------------------
`define OPA_GRP_RST 32'h00005008
`define OPA_GRP_DIV 10:0
`define OPA_GRP_DDLY 19:12
`define OPA_GRP_HS 24
`define OPA_GRP_PD 25
`define OPA_GRP_EXEMPT 26
`define OPA_REFDIV_RST 32'h00000001
`define OPA_RESP_OK 2'h0
`define OPA_RESP_ERR 2'h2
`endif

// [core/opa_pkg.sv]
// Types for the output phase alignment and feedback block.
// Assumes opa_params.svh on the include path.
`include "opa_params.svh"
package opa_pkg;
   typedef struct packed {
      logic [10:0] div;
      logic [7:0] ddly;
      logic hs;
      logic pd;
      logic exempt;
   } opa_grp_cfg_t;
   typedef enum logic [1:0] {ST_IDLE, ST_QUAL1, ST_QUAL2, ST_SHOT} opa_state_t;
endpackage

// [core/opa_sync3.sv]
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous single-bit input.
`timescale 1ns/1ps
module opa_sync3 (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic ce,
   // Data
   input wire logic din,
   output logic dout
);
   logic s1_q, s2_q, s3_q, out_q, out_d;
   // Stage one feeds stage two only, to keep metastability contained
   always_comb begin
      out_d = (s2_q == s3_q) ? s3_q : out_q;
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         out_q <= 1'b0;
      end else if (ce) begin
         s1_q <= din;
         s2_q <= s1_q;
         s3_q <= s2_q;
         out_q <= out_d;
      end
   end
   assign dout = out_q;
endmodule

// [verif/opa_align_asserts.sv]
// Checker for the alignment block ports.
// Assumes full-word control writes and no bus traffic while ce is low.
`timescale 1ns/1ps
`include "opa_params.svh"
module opa_align_asserts (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Bus
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Pins and outputs
   input wire logic digital_lock_detect,
   input wire logic [`OPA_NUM_GRP-1:0] groupClk,
   input wire logic fbClk,
   input wire logic zeroDelayMode,
   input wire logic holdEnter
);
   // ----
   // Control shadow, judged only once settled
   // ----
   logic [31:0] ctrl_q, ctrl_d;
   logic [2:0] age_q, age_d;
   wire settled = age_q > 3'h3;
   wire zdExp = ctrl_q[11:8] == 4'h2 || ctrl_q[11:8] == 4'h5;
   always_comb begin
      ctrl_d = ctrl_q;
      age_d = (age_q == 3'h7) ? age_q : age_q + 3'h1;
      if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `OPA_ADDR_CTRL) begin
         ctrl_d = s_axi_wdata;
         age_d = 3'h0;
      end
   end
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_q <= `OPA_CTRL_RST;
         age_q <= 3'h0;
      end else begin
         ctrl_q <= ctrl_d;
         age_q <= age_d;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   a_zd_mode: assert property (settled |-> zeroDelayMode == zdExp)
      else $error("zero delay flag wrong");
   a_fb_gate: assert property (settled && !(zdExp && ctrl_q[3]) |-> !fbClk)
      else $error("feedback clock not gated");
   a_fb_route: assert property (settled && zdExp && ctrl_q[3] && ctrl_q[6:4] == 3'h1
      |-> fbClk == $past(groupClk[1]))
      else $error("feedback not second group");
   a_hold_mask: assert property (settled && ctrl_q[12] |-> !holdEnter)
      else $error("hold despite mask");
   a_hold_lock: assert property (digital_lock_detect [*8] |-> !holdEnter)
      else $error("hold while locked");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   a_aw_busy: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("write taken while busy");
   a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer late");
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data dropped");
   c_zero_delay: cover property (zeroDelayMode && fbClk);
   c_hold: cover property ($rose(holdEnter));
   c_forced: cover property (groupClk[3:2] == 2'b00 && groupClk[0]);
endmodule
bind opa_align_top opa_align_asserts u_chk (.*);

// [verif/opa_host_model.sv]
// Host controller pins facing the alignment block.
// Assumes the bench calls its tasks just after a rising sys_clk edge.
`timescale 1ns/1ps
module opa_host_model (
   // Clock
   input wire logic sys_clk,
   // Pins toward the device
   output logic alignPin,
   output logic external_feedback_input,
   output logic digital_lock_detect
);
   initial begin
      alignPin = 1'b0;
      external_feedback_input = 1'b0;
      digital_lock_detect = 1'b1;
   end
   // ----
   // Pin actions
   // ----
   // A toggle that raises the request level is enough, the device makes its own one-shot
   task automatic toggle_pin();
      @(posedge sys_clk);
      alignPin <= !alignPin;
   endtask
   // Feedback clock runs only while asked and rests low between bursts
   task automatic fb_pulses(input int n);
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         external_feedback_input <= 1'b1;
         repeat (4) @(posedge sys_clk);
         external_feedback_input <= 1'b0;
      end
   endtask
   task automatic set_lock(input logic v);
      @(posedge sys_clk);
      digital_lock_detect <= v;
   endtask
endmodule

// [verif/output_phase_align_and_feedback_tb_top.sv]
// Self-checking bench for the alignment block.
// Assumes the host model drives the pins and the bench is bus master.
`timescale 1ns/1ps
`include "opa_params.svh"
module output_phase_align_and_feedback_tb_top;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv;
   logic ce = 1'b1;
   logic [3:0] wstrb = 4'hF;
   logic [1:0] bresp, rresp, rr;
   logic awready, wready, bvalid, arready, rvalid, fbClk, zdm, holdEnter, alignPin, extFb, lock;
   logic [5:0] grp;
   logic [24:0] loopDiv;
   int num_errors = 0, cmp_count = 0;
   always #2.5 sys_clk = ~sys_clk;
   opa_host_model u_host (.sys_clk(sys_clk), .alignPin(alignPin), .external_feedback_input(extFb),
      .digital_lock_detect(lock));
   opa_align_top u_dut (.sys_clk(sys_clk), .rst_b(rst_b), .ce(ce),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .alignPin(alignPin), .external_feedback_input(extFb), .digital_lock_detect(lock),
      .groupClk(grp), .fbClk(fbClk), .zeroDelayMode(zdm), .loopDivide(loopDiv),
      .holdEnter(holdEnter));
   // ----
   // Shared tasks
   // ----
   task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // Address and data offered together; an edge passes before the next call
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(posedge sys_clk); while (awready !== 1'b1);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(posedge sys_clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      check("bresp", er, bresp);
      @(posedge sys_clk);
   endtask
   task automatic rd(input logic [7:0] a);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rv = rdata;
      rr = rresp;
      rready <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic print_verdict();
      $display("errors %0d comparisons %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_regs();
      rd(`OPA_ADDR_CTRL);
      check("ctrl", `OPA_CTRL_RST, rv);
      rd(`OPA_ADDR_REFDIV);
      check("refdiv", `OPA_REFDIV_RST, rv);
      for (int g = 0; g < 6; g++) begin
         rd(`OPA_ADDR_GRP0 + 8'(4 * g));
         check("group", `OPA_GRP_RST, rv);
      end
      rd(8'h0C);
      check("rresp", `OPA_RESP_ERR, rr);
      check("rdata", 32'h0, rv);
      wr(8'h0C, 32'h1, `OPA_RESP_ERR);
      // Only byte lane one may land
      wstrb <= 4'h2;
      wr(`OPA_ADDR_REFDIV, 32'hFFFFABFF, `OPA_RESP_OK);
      wstrb <= 4'hF;
      rd(`OPA_ADDR_REFDIV);
      check("refdiv lane", 32'h0000AB01, rv);
   endtask
   task automatic t_modes();
      for (int m = 0; m < 16; m++) begin
         wr(`OPA_ADDR_CTRL, 32'h9 | (32'(m) << 8), `OPA_RESP_OK);
         repeat (3) @(posedge sys_clk);
         rd(`OPA_ADDR_STAT);
         check("zero delay", m == 2 || m == 5, rv[2]);
      end
   endtask
   task automatic t_loop();
      int hi;
      hi = 0;
      wr(`OPA_ADDR_REFDIV, 32'h7, `OPA_RESP_OK);
      wr(`OPA_ADDR_GRP0 + 8'h04, 32'h0000500C, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h219, `OPA_RESP_OK);
      repeat (4) @(posedge sys_clk);
      check("loop group", 32'd84, loopDiv);
      wr(`OPA_ADDR_CTRL, 32'h269, `OPA_RESP_OK);
      repeat (4) @(posedge sys_clk);
      check("loop ext", 32'd7, loopDiv);
      fork
         u_host.fb_pulses(2);
         repeat (24) begin
            @(posedge sys_clk);
            if (fbClk === 1'b1) hi++;
         end
      join
      check("fb seen", 1'b1, hi > 0);
      u_host.set_lock(1'b0);
      repeat (8) @(posedge sys_clk);
      check("hold", 1'b1, holdEnter);
      wr(`OPA_ADDR_CTRL, 32'h1269, `OPA_RESP_OK);
      repeat (4) @(posedge sys_clk);
      check("hold masked", 1'b0, holdEnter);
      u_host.set_lock(1'b1);
   endtask
   // Qualified by the external input: no falls, no sequence end
   task automatic t_qual();
      wr(`OPA_ADDR_CTRL, 32'h6B, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h6F, `OPA_RESP_OK);
      repeat (20) @(posedge sys_clk);
      rd(`OPA_ADDR_STAT);
      check("busy none", 1'b1, rv[0]);
      u_host.fb_pulses(1);
      repeat (8) @(posedge sys_clk);
      rd(`OPA_ADDR_STAT);
      check("busy one", 1'b1, rv[0]);
      u_host.fb_pulses(1);
      repeat (30) @(posedge sys_clk);
      rd(`OPA_ADDR_STAT);
      check("busy two", 1'b0, rv[0]);
   endtask
   // Second trigger lands in the high phase, so the forced fall is visible
   task automatic t_align();
      int lo2, lo3, run, maxRun;
      logic prev0;
      wr(`OPA_ADDR_GRP0, 32'h04005008, `OPA_RESP_OK);
      wr(`OPA_ADDR_GRP0 + 8'h08, 32'h00002040, `OPA_RESP_OK);
      wr(`OPA_ADDR_GRP0 + 8'h0C, 32'h00006040, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h1, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h5, `OPA_RESP_OK);
      repeat (80) @(posedge sys_clk);
      u_host.toggle_pin();
      repeat (10) @(posedge sys_clk);
      while (grp[2] !== 1'b0) @(posedge sys_clk);
      while (grp[2] !== 1'b1) @(posedge sys_clk);
      u_host.toggle_pin();
      while (grp[2] !== 1'b0) @(posedge sys_clk);
      lo2 = 0;
      lo3 = 0;
      run = 0;
      maxRun = 0;
      prev0 = grp[0];
      for (int i = 0; i < 30; i++) begin
         if (grp[2] === 1'b0) lo2++;
         if (grp[3] === 1'b0) lo3++;
         run = (grp[0] === prev0) ? run + 1 : 1;
         prev0 = grp[0];
         if (run > maxRun) maxRun = run;
         @(posedge sys_clk);
      end
      // Low from five after shot start until five plus delay after its end
      check("low span g2", 32'(`OPA_SHOT_LEN) + 32'd2, lo2);
      check("low span g3", 32'(`OPA_SHOT_LEN) + 32'd6, lo3);
      check("exempt run", 32'd4, maxRun);
   endtask
   // Second group qualifies its own alignment, stepped with delay nine
   task automatic t_rel();
      int run, maxLow;
      run = 0;
      maxLow = 0;
      wr(`OPA_ADDR_GRP0 + 8'h04, 32'h00009008, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h1B, `OPA_RESP_OK);
      wr(`OPA_ADDR_CTRL, 32'h1F, `OPA_RESP_OK);
      for (int i = 0; i < 48; i++) begin
         @(posedge sys_clk);
         run = (grp[1] === 1'b0) ? run + 1 : 0;
         if (run > maxLow) maxLow = run;
      end
      check("rel low span", 32'(`OPA_SHOT_LEN) + 32'd9, maxLow);
      rd(`OPA_ADDR_STAT);
      check("rel busy", 32'h0, rv[1:0]);
      wr(`OPA_ADDR_GRP0 + 8'h04, 32'h01009008, `OPA_RESP_OK);
      wr(`OPA_ADDR_GRP0 + 8'h04, 32'h00009008, `OPA_RESP_OK);
   endtask
   // Clock enable low must hold every group clock still, then the exempt group resumes
   task automatic t_freeze();
      logic [5:0] snap;
      int moved;
      moved = 0;
      ce <= 1'b0;
      @(posedge sys_clk);
      snap = grp;
      repeat (10) begin
         @(posedge sys_clk);
         if (grp !== snap) moved++;
      end
      check("frozen", 32'h0, moved);
      ce <= 1'b1;
      moved = 0;
      snap = grp;
      repeat (17) begin
         @(posedge sys_clk);
         if (grp[0] !== snap[0]) moved++;
         snap = grp;
      end
      check("exempt toggles", 32'd4, moved);
   endtask
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      @(posedge sys_clk);
      t_regs();
      t_modes();
      t_loop();
      t_qual();
      t_align();
      t_rel();
      t_freeze();
      print_verdict();
   end
   // Whole run needs under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end
endmodule
